// >>> rtl/accel_pkg.sv
// Shared constants, types and decode functions for the accelerometer mode and output block
package accel_pkg;

  // ****************************************************************
  // Clock and input filter timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS = 4000;  // 250 MHz system clock
  localparam int unsigned SPIKE_MAX_NS  = 50;    // Longest spike to suppress
  // Least stable time rounds up, plus one so a full spike never passes
  localparam int unsigned SPIKE_CYC     =
    (SPIKE_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  localparam int unsigned SPIKE_CNT_W   = $clog2(SPIKE_CYC + 1);
  localparam logic [SPIKE_CNT_W-1:0] SPIKE_CNT_LAST = SPIKE_CNT_W'(SPIKE_CYC - 1);

  // ****************************************************************
  // Data widths and scaling
  // ****************************************************************
  localparam int unsigned AXES      = 3;       // X, Y, Z
  localparam int unsigned RAW_W     = 16;      // Front end word, 4096 counts/g
  localparam int unsigned OUT_W     = 14;      // Output word, two's complement
  localparam logic [OUT_W-1:0] OUT_RESET = 14'h0000;  // Zero g
  localparam logic [OUT_W-1:0] OUT_POS_MAX = 14'h1fff; // Largest positive code
  localparam logic [OUT_W-1:0] OUT_NEG_MAX = 14'h2000; // Most negative code
  localparam int OUT_MAX_INT = 8191;
  localparam int OUT_MIN_INT = -8192;

  // Full-scale select codes
  localparam logic [1:0] FS_2G = 2'h0;  // 4096 counts/g
  localparam logic [1:0] FS_4G = 2'h1;  // 2048 counts/g
  localparam logic [1:0] FS_8G = 2'h2;  // 1024 counts/g

  // ****************************************************************
  // System mode
  // ****************************************************************
  typedef enum logic [3:0] {
    MODE_OFF     = 4'h1,
    MODE_STANDBY = 4'h2,
    MODE_WAKE    = 4'h4,
    MODE_SLEEP   = 4'h8
  } sys_mode_t;

  // Codes reported on the mode status field
  localparam logic [1:0] STAT_STANDBY = 2'h0;
  localparam logic [1:0] STAT_WAKE    = 2'h1;
  localparam logic [1:0] STAT_SLEEP   = 2'h2;

  // Right shift that turns 4096 counts/g into the selected sensitivity
  function automatic logic [1:0] fs_shift(input logic [1:0] fs);
    unique case (fs)
      FS_2G:   fs_shift = 2'h0;
      FS_4G:   fs_shift = 2'h1;
      default: fs_shift = 2'h2;  // 8 g, and the unused code
    endcase
  endfunction

endpackage

// >>> rtl/accel_axis_if.sv
// Per-axis link between the mode controller and an output formatter
`timescale 1ns/100ps
`default_nettype none

interface accel_axis_if;
  logic                     load;      // Take a new sample this cycle
  logic [1:0]               fs;        // Full-scale select
  logic                     st_en;     // Self-test force applied
  logic signed [15:0]       raw;       // Front end acceleration
  logic signed [15:0]       st_force;  // Signal from the test force
  logic signed [13:0]       data;      // Formatted output word

  modport ctrl (output load, fs, st_en, raw, st_force, input data);
  modport fmt  (input load, fs, st_en, raw, st_force, output data);
endinterface

`default_nettype wire

// >>> rtl/spike_filter.sv
// Two-flop synchroniser and spike suppressor for one bus input pin
`timescale 1ns/100ps
`default_nettype none

module spike_filter #(
  parameter logic IDLE_LEVEL = 1'b1  // Bus lines idle high
) (
  input  wire logic sys_clk_in,
  input  wire logic srst_in,
  input  wire logic pin_in,
  output logic      level_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                                s1;     // Sync stage one
    logic                                s2;     // Sync stage two
    logic [accel_pkg::SPIKE_CNT_W-1:0]   cnt;    // Cycles the input differed
    logic                                level;  // Accepted level
  } filt_state_t;

  filt_state_t st_r;   // Registered state
  filt_state_t st_nxt; // Next state

  // Accept a new level only after it has held for the full spike window
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    if (st_r.s2 == st_r.level) begin
      // Input agrees, any partial spike is forgotten
      st_nxt.cnt = '0;
    end else if (st_r.cnt == accel_pkg::SPIKE_CNT_LAST) begin
      // Held long enough to be a real edge
      st_nxt.level = st_r.s2;
      st_nxt.cnt   = '0;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st_r <= '{s1: IDLE_LEVEL, s2: IDLE_LEVEL, cnt: '0, level: IDLE_LEVEL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.level;

  // A level change must be preceded by a full window of disagreement
  property p_spike_window;
    @(posedge sys_clk_in) disable iff (srst_in)
      $changed(st_r.level) |-> $past(st_r.cnt) == accel_pkg::SPIKE_CNT_LAST;
  endproperty
  a_spike_window: assert property (p_spike_window)
    else $error("Filtered level changed before the spike window ran out");

endmodule

`default_nettype wire

// >>> rtl/accel_formatter.sv
// Output formatter for one axis: self-test sum, range scaling, saturation
`timescale 1ns/100ps
`default_nettype none

module accel_formatter (
  input  wire logic     sys_clk_in,
  input  wire logic     srst_in,
  accel_axis_if.fmt     bus
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic signed [13:0] data;  // Held output word
  } fmt_state_t;

  fmt_state_t         st_r;    // Registered state
  fmt_state_t         st_nxt;  // Next state
  logic signed [16:0] sum;     // Acceleration plus test force
  logic signed [16:0] scaled;  // Sum at selected sensitivity

  // Form the next output word on a load, otherwise hold it
  always_comb begin
    st_nxt = st_r;
    // Test force adds to the real signal while self-test is on
    sum    = 17'({bus.raw[15], bus.raw}) + (bus.st_en ?
             17'({bus.st_force[15], bus.st_force}) : 17'h0_0000);
    // 4096, 2048 or 1024 counts per g
    scaled = sum >>> accel_pkg::fs_shift(bus.fs);
    if (bus.load) begin
      // Signed two's complement, clipped at the ends of the range
      if (scaled > 17'(accel_pkg::OUT_MAX_INT)) begin
        st_nxt.data = accel_pkg::OUT_POS_MAX;
      end else if (scaled < 17'(accel_pkg::OUT_MIN_INT)) begin
        st_nxt.data = accel_pkg::OUT_NEG_MAX;
      end else begin
        st_nxt.data = scaled[13:0];
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st_r <= '{data: accel_pkg::OUT_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.data = st_r.data;

  // In the 2 g range an in-range sample appears one count per count
  property p_scale_2g;
    @(posedge sys_clk_in) disable iff (srst_in)
      bus.load && bus.fs == accel_pkg::FS_2G && !bus.st_en &&
      bus.raw <= 16'sd8191 && bus.raw >= -16'sd8192
      |=> 16'(st_r.data) == $past(bus.raw);
  endproperty
  a_scale_2g: assert property (p_scale_2g)
    else $error("2 g output does not equal the input sample");

  // Under self-test in 8 g the word is a quarter of signal plus force
  property p_self_test_8g;
    @(posedge sys_clk_in) disable iff (srst_in)
      bus.load && bus.fs == accel_pkg::FS_8G && bus.st_en
      |=> 17'(st_r.data) * 4 + 17'sd3 >= 17'($past(bus.raw)) + 17'($past(bus.st_force))
       && 17'(st_r.data) * 4 <= 17'($past(bus.raw)) + 17'($past(bus.st_force));
  endproperty
  a_self_test_8g: assert property (p_self_test_8g)
    else $error("Self-test output is not the scaled sum of signal and force");

endmodule

`default_nettype wire

// >>> rtl/accel_mode_ctrl.sv
// Mode control, bus pin conditioning and output data path of the accelerometer
// Operation
// - Sensitivity 4096, 2048, 1024 counts per g.
// - Outputs are signed two's complement, zero mid-range.
// - Self-test output sums acceleration and test force.
// - Never hold the serial clock low.
// - Ignore spikes up to 50 ns on bus.
// - Off: everything shut down, bus left alone.
// - Standby: digital only, clocks stopped, registers accessible.
// - Active: analog and digital run, bus accepted.
// - Active to standby keeps every register.
// - Standby to active resets the designated registers.
// - Wake and sleep are both active substates.
`timescale 1ns/100ps
`default_nettype none

module accel_mode_ctrl (
  input  wire logic                sys_clk_in,          // 250 MHz clock
  input  wire logic                srst_in,             // Synchronous reset
  input  wire logic                power_good_in,       // Supply above threshold, async
  input  wire logic                active_req_in,       // Active mode requested
  input  wire logic                sleep_req_in,        // Auto-sleep condition met
  input  wire logic [1:0]          fs_sel_in,           // Full-scale select
  input  wire logic                self_test_in,        // Self-test enable
  input  wire logic                sample_valid_in,     // Front end has a sample
  input  wire logic [2:0][15:0]    raw_accel_in,        // Per-axis acceleration
  input  wire logic [2:0][15:0]    st_force_in,         // Per-axis test force signal
  input  wire logic                sda_drive_low_in,    // Protocol engine pulls data low
  input  wire logic                scl_in,              // Serial clock pin level
  input  wire logic                sda_in,              // Serial data pin level
  output logic                     scl_out,             // Serial clock drive value
  output logic                     scl_oe_out,          // Serial clock drive enable
  output logic                     sda_out,             // Serial data drive value
  output logic                     sda_oe_out,          // Serial data drive enable
  output logic                     scl_filt_out,        // Filtered serial clock
  output logic                     sda_filt_out,        // Filtered serial data
  output logic                     i2c_en_out,          // Protocol engine may respond
  output logic                     digital_en_out,      // Digital blocks powered
  output logic                     analog_en_out,       // Analog subsystem powered
  output logic                     sample_clk_en_out,   // Internal sampling clock runs
  output logic                     reg_reset_out,       // Reset designated registers
  output logic [1:0]               system_mode_status_out, // Standby, wake or sleep
  output logic [2:0][13:0]         accel_out            // Formatted output words
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                  pg_s1;      // Power good sync stage one
    logic                  pg_s2;      // Power good sync stage two
    accel_pkg::sys_mode_t  mode;       // Current system mode
    logic [1:0]            status;     // Mode status code
    logic                  i2c_en;     // Bus participation allowed
    logic                  digital_en; // Digital enable
    logic                  analog_en;  // Analog enable
    logic                  sample_en;  // Sampling clock enable
    logic                  reg_reset;  // One-cycle register reset
    logic                  sda_oe;     // Data line pulled low
    logic                  scl_oe;     // Clock line drive, always off
  } ctrl_state_t;

  ctrl_state_t st_r;   // Registered state
  ctrl_state_t st_nxt; // Next state

  // ****************************************************************
  // Mode sequencing and enables
  // ****************************************************************
  // Enables follow the next mode so they line up with the mode register
  always_comb begin
    st_nxt           = st_r;
    st_nxt.pg_s1     = power_good_in;
    st_nxt.pg_s2     = st_r.pg_s1;
    st_nxt.reg_reset = 1'b0;
    if (!st_r.pg_s2) begin
      // Supply lost: drop to off from any mode
      st_nxt.mode = accel_pkg::MODE_OFF;
    end else begin
      unique case (st_r.mode)
        accel_pkg::MODE_OFF: begin
          st_nxt.mode = accel_pkg::MODE_STANDBY;
        end
        accel_pkg::MODE_STANDBY: begin
          if (active_req_in) begin
            st_nxt.mode      = accel_pkg::MODE_WAKE;
            st_nxt.reg_reset = 1'b1;
          end
        end
        accel_pkg::MODE_WAKE: begin
          if (!active_req_in) begin
            // Leaving active keeps all registers, no reset pulse
            st_nxt.mode = accel_pkg::MODE_STANDBY;
          end else if (sleep_req_in) begin
            st_nxt.mode = accel_pkg::MODE_SLEEP;
          end
        end
        accel_pkg::MODE_SLEEP: begin
          if (!active_req_in) begin
            st_nxt.mode = accel_pkg::MODE_STANDBY;
          end else if (!sleep_req_in) begin
            st_nxt.mode = accel_pkg::MODE_WAKE;
          end
        end
        default: begin
          // Illegal code recovers through off
          st_nxt.mode = accel_pkg::MODE_OFF;
        end
      endcase
    end
    // Block enables per mode
    unique case (st_nxt.mode)
      accel_pkg::MODE_STANDBY: begin
        st_nxt.digital_en = 1'b1;
        st_nxt.analog_en  = 1'b0;
        st_nxt.sample_en  = 1'b0;
        st_nxt.i2c_en     = 1'b1;
        st_nxt.status     = accel_pkg::STAT_STANDBY;
      end
      accel_pkg::MODE_WAKE: begin
        st_nxt.digital_en = 1'b1;
        st_nxt.analog_en  = 1'b1;
        st_nxt.sample_en  = 1'b1;
        st_nxt.i2c_en     = 1'b1;
        st_nxt.status     = accel_pkg::STAT_WAKE;
      end
      accel_pkg::MODE_SLEEP: begin
        st_nxt.digital_en = 1'b1;
        st_nxt.analog_en  = 1'b1;
        st_nxt.sample_en  = 1'b1;
        st_nxt.i2c_en     = 1'b1;
        st_nxt.status     = accel_pkg::STAT_SLEEP;
      end
      default: begin
        // Off: all blocks down, bus not touched
        st_nxt.digital_en = 1'b0;
        st_nxt.analog_en  = 1'b0;
        st_nxt.sample_en  = 1'b0;
        st_nxt.i2c_en     = 1'b0;
        st_nxt.status     = accel_pkg::STAT_STANDBY;
      end
    endcase
    // Data line only pulled while bus participation is allowed
    st_nxt.sda_oe = sda_drive_low_in && st_nxt.i2c_en;
    // Clock line is left to the master, so its low period is never stretched
    st_nxt.scl_oe = 1'b0;
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st_r <= '{pg_s1: 1'b0, pg_s2: 1'b0, mode: accel_pkg::MODE_OFF,
                status: accel_pkg::STAT_STANDBY, i2c_en: 1'b0,
                digital_en: 1'b0, analog_en: 1'b0, sample_en: 1'b0,
                reg_reset: 1'b0, sda_oe: 1'b0, scl_oe: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Bus pins
  // ****************************************************************
  // Clock line is never driven, so no stretching; data is open drain
  assign scl_out                = 1'b0;
  assign scl_oe_out             = st_r.scl_oe;
  assign sda_out                = 1'b0;
  assign sda_oe_out             = st_r.sda_oe;
  assign i2c_en_out             = st_r.i2c_en;
  assign digital_en_out         = st_r.digital_en;
  assign analog_en_out          = st_r.analog_en;
  assign sample_clk_en_out      = st_r.sample_en;
  assign reg_reset_out          = st_r.reg_reset;
  assign system_mode_status_out = st_r.status;

  // Spike suppression on both bus inputs
  spike_filter #(
    .IDLE_LEVEL (1'b1)
  ) u_scl_filt (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .pin_in     (scl_in),
    .level_out  (scl_filt_out)
  );

  spike_filter #(
    .IDLE_LEVEL (1'b1)
  ) u_sda_filt (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .pin_in     (sda_in),
    .level_out  (sda_filt_out)
  );

  // ****************************************************************
  // Output data path
  // ****************************************************************
  // Samples load only while sampling runs, so standby holds the words
  for (genvar g = 0; g < accel_pkg::AXES; g++) begin : g_axis
    accel_axis_if axis_bus ();
    assign axis_bus.load     = sample_valid_in && st_r.sample_en;
    assign axis_bus.fs       = fs_sel_in;
    assign axis_bus.st_en    = self_test_in;
    assign axis_bus.raw      = raw_accel_in[g];
    assign axis_bus.st_force = st_force_in[g];
    assign accel_out[g]      = axis_bus.data;

    accel_formatter u_fmt (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .bus        (axis_bus.fmt)
    );
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_no_stretch;
    @(posedge sys_clk_in) disable iff (srst_in)
      !scl_oe_out;
  endproperty
  a_no_stretch: assert property (p_no_stretch)
    else $error("Serial clock line driven by the device");

  property p_off_quiet;
    @(posedge sys_clk_in) disable iff (srst_in)
      st_r.mode == accel_pkg::MODE_OFF
      |-> !sda_oe_out && !i2c_en_out && !analog_en_out && !digital_en_out;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("Device active or on the bus while off");

  property p_standby_blocks;
    @(posedge sys_clk_in) disable iff (srst_in)
      st_r.mode == accel_pkg::MODE_STANDBY
      |-> digital_en_out && i2c_en_out && !analog_en_out && !sample_clk_en_out;
  endproperty
  a_standby_blocks: assert property (p_standby_blocks)
    else $error("Wrong block enables in standby");

  property p_active_blocks;
    @(posedge sys_clk_in) disable iff (srst_in)
      st_r.mode inside {accel_pkg::MODE_WAKE, accel_pkg::MODE_SLEEP}
      |-> analog_en_out && digital_en_out && i2c_en_out && sample_clk_en_out;
  endproperty
  a_active_blocks: assert property (p_active_blocks)
    else $error("Active mode without all blocks enabled");

  property p_retain;
    @(posedge sys_clk_in) disable iff (srst_in)
      st_r.mode inside {accel_pkg::MODE_WAKE, accel_pkg::MODE_SLEEP} ##1
      st_r.mode == accel_pkg::MODE_STANDBY
      |-> !reg_reset_out ##1 $stable(accel_out);
  endproperty
  a_retain: assert property (p_retain)
    else $error("Registers disturbed on entry to standby");

  property p_reset_pulse;
    @(posedge sys_clk_in) disable iff (srst_in)
      st_r.mode == accel_pkg::MODE_STANDBY && st_r.pg_s2 && active_req_in
      |=> reg_reset_out && st_r.mode == accel_pkg::MODE_WAKE ##1 !reg_reset_out;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("No single reset pulse on entry to active");

  property p_status;
    @(posedge sys_clk_in) disable iff (srst_in)
      st_r.mode == accel_pkg::MODE_SLEEP |-> system_mode_status_out ==
      accel_pkg::STAT_SLEEP && $past(st_r.mode) inside
      {accel_pkg::MODE_WAKE, accel_pkg::MODE_SLEEP};
  endproperty
  a_status: assert property (p_status)
    else $error("Sleep status wrong or sleep entered from outside active");

  // Wake always reports the wake code
  property p_status_wake;
    @(posedge sys_clk_in) disable iff (srst_in)
      st_r.mode == accel_pkg::MODE_WAKE |-> system_mode_status_out == accel_pkg::STAT_WAKE;
  endproperty
  a_status_wake: assert property (p_status_wake)
    else $error("Wake mode shows the wrong status code");

  // Register reset pulse only on the first wake cycle after standby
  property p_reset_entry;
    @(posedge sys_clk_in) disable iff (srst_in)
      reg_reset_out |-> st_r.mode == accel_pkg::MODE_WAKE &&
      $past(st_r.mode) == accel_pkg::MODE_STANDBY;
  endproperty
  a_reset_entry: assert property (p_reset_entry)
    else $error("Register reset pulse outside standby to active entry");

  // A supply loss seen at the second sync stage takes the device off at the next edge
  property p_power_loss;
    @(posedge sys_clk_in) disable iff (srst_in)
      !st_r.pg_s2 |=> st_r.mode == accel_pkg::MODE_OFF;
  endproperty
  a_power_loss: assert property (p_power_loss)
    else $error("Device stayed powered after supply loss");

  // Data line pulled only while bus traffic is allowed
  property p_sda_gate;
    @(posedge sys_clk_in) disable iff (srst_in)
      sda_oe_out |-> i2c_en_out && st_r.mode != accel_pkg::MODE_OFF;
  endproperty
  a_sda_gate: assert property (p_sda_gate)
    else $error("Data line pulled while bus traffic is inhibited");

endmodule

`default_nettype wire

// >>> verif/i2c_host_model.sv
// Bus master model: open-drain wires with pull-ups, shared by host and device
`timescale 1ns/100ps
`default_nettype none

module i2c_host_model (
  input  wire logic scl_low_in,  // Host pulls the clock low
  input  wire logic sda_low_in,  // Host pulls the data low
  input  wire logic dev_scl_in,  // Device clock drive value
  input  wire logic dev_scl_oe_in, // Device clock drive enable
  input  wire logic dev_sda_in,  // Device data drive value
  input  wire logic dev_sda_oe_in, // Device data drive enable
  output logic      scl_out,     // Resolved clock wire
  output logic      sda_out      // Resolved data wire
);
  // ****************************************************************
  // Wire resolution
  // ****************************************************************
  // Pull-ups hold a released wire high; any party may pull it low
  assign scl_out = !(scl_low_in || (dev_scl_oe_in && !dev_scl_in));
  assign sda_out = !(sda_low_in || (dev_sda_oe_in && !dev_sda_in));
endmodule

`default_nettype wire

// >>> verif/accel_mode_and_output_format_bench.sv
// Self-checking bench for the accelerometer mode and output block
`timescale 1ns/100ps
`default_nettype none

module accel_mode_and_output_format_bench;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic clk = 0, srst = 1, pgood = 1, act = 0, slp = 0, st = 0, vld = 0;
  logic sdrv = 0, h_scl_low = 0, h_sda_low = 0;
  logic [1:0] fs = 2'h0;
  logic [2:0][15:0] raw = '0, frc = '0;
  logic scl_w, sda_w, scl_o, scl_oe, sda_o, sda_oe, scl_f, sda_f;
  logic i2c_en, dig_en, ana_en, smp_en, reg_rst;
  logic [1:0] stat;
  logic [2:0][13:0] acc;
  int error_cnt = 0, comparisons = 0, scl_drives = 0;

  always #2 clk = ~clk;

  accel_mode_ctrl accel_mode_ctrl_i (.sys_clk_in(clk), .srst_in(srst), .power_good_in(pgood),
    .active_req_in(act), .sleep_req_in(slp), .fs_sel_in(fs), .self_test_in(st),
    .sample_valid_in(vld), .raw_accel_in(raw), .st_force_in(frc), .sda_drive_low_in(sdrv),
    .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .scl_filt_out(scl_f), .sda_filt_out(sda_f), .i2c_en_out(i2c_en),
    .digital_en_out(dig_en), .analog_en_out(ana_en), .sample_clk_en_out(smp_en),
    .reg_reset_out(reg_rst), .system_mode_status_out(stat), .accel_out(acc));

  i2c_host_model i2c_host_model_i (.scl_low_in(h_scl_low), .sda_low_in(h_sda_low),
    .dev_scl_in(scl_o), .dev_scl_oe_in(scl_oe), .dev_sda_in(sda_o),
    .dev_sda_oe_in(sda_oe), .scl_out(scl_w), .sda_out(sda_w));

  // Counts every cycle in which the device drives the clock wire
  always @(posedge clk) if (!srst && scl_oe !== 1'b0) scl_drives++;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Loads one sample on all axes and compares every axis
  task automatic sample(input logic [1:0] f, input logic s, input logic [15:0] r,
                        input logic [15:0] k, input logic [13:0] exp);
    fs = f; st = s; raw = {3{r}}; frc = {3{k}}; vld = 1;
    tick(1);
    vld = 0;
    tick(1);
    for (int a = 0; a < 3; a++) check("accel_out", acc[a], exp);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_standby();
    check("status", stat, 2'h0);
    check("digital_en", dig_en, 1'b1);
    check("analog_en", ana_en, 1'b0);
    check("sample_clk_en", smp_en, 1'b0);
    sdrv = 1;
    tick(2);
    check("sda_oe", sda_oe, 1'b1);
    check("sda_wire", sda_w, 1'b0);
    check("i2c_en", i2c_en, 1'b1);
    check("scl_out", scl_o, 1'b0);
    sdrv = 0;
    tick(2);
  endtask

  task automatic t_active();
    act = 1;
    tick(1);
    check("status", stat, 2'h1);
    check("analog_en", ana_en, 1'b1);
    check("sample_clk_en", smp_en, 1'b1);
    check("i2c_en", i2c_en, 1'b1);
    check("reg_reset", reg_rst, 1'b1);
    slp = 1;
    tick(1);
    check("reg_reset", reg_rst, 1'b0);
    check("status", stat, 2'h2);
    check("analog_en", ana_en, 1'b1);
    check("digital_en", dig_en, 1'b1);
    slp = 0;
    tick(1);
    check("status", stat, 2'h1);
  endtask

  task automatic t_data();
    sample(2'h0, 0, 16'h1000, 16'h0000, 14'h1000);
    sample(2'h1, 0, 16'h1000, 16'h0000, 14'h0800);
    sample(2'h2, 0, 16'h1000, 16'h0000, 14'h0400);
    sample(2'h3, 0, 16'h1000, 16'h0000, 14'h0400);
    sample(2'h0, 0, 16'hf000, 16'h0000, 14'h3000);
    sample(2'h0, 0, 16'h0000, 16'h0200, 14'h0000);
    sample(2'h1, 1, 16'h1000, 16'h0200, 14'h0900);
    sample(2'h2, 1, 16'h1000, 16'h0203, 14'h0480);
    sample(2'h0, 0, 16'hc000, 16'h0000, 14'h2000);
    sample(2'h0, 0, 16'h4000, 16'h0000, 14'h1fff);
  endtask

  task automatic t_to_standby();
    act = 0;
    tick(1);
    check("status", stat, 2'h0);
    check("analog_en", ana_en, 1'b0);
    check("reg_reset", reg_rst, 1'b0);
    sample(2'h0, 0, 16'h0100, 16'h0000, 14'h1fff);
  endtask

  task automatic t_spike();
    logic seen_low;
    seen_low = 0;
    h_scl_low = 1;
    h_sda_low = 1;
    tick(12);
    h_scl_low = 0;
    h_sda_low = 0;
    repeat (30) begin
      tick(1);
      if (scl_f !== 1'b1 || sda_f !== 1'b1) seen_low = 1;
    end
    check("filt_spike", seen_low, 1'b0);
    h_scl_low = 1;
    h_sda_low = 1;
    tick(30);
    check("scl_filt_low", scl_f, 1'b0);
    check("sda_filt_low", sda_f, 1'b0);
    h_scl_low = 0;
    h_sda_low = 0;
    tick(30);
    check("scl_filt_high", scl_f, 1'b1);
    check("sda_filt_high", sda_f, 1'b1);
    check("scl_drives", scl_drives, 32'h0000_0000);
  endtask

  task automatic t_off();
    pgood = 0;
    sdrv = 1;
    act = 1;
    tick(6);
    check("digital_en", dig_en, 1'b0);
    check("analog_en", ana_en, 1'b0);
    check("i2c_en", i2c_en, 1'b0);
    check("sda_oe", sda_oe, 1'b0);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    tick(2);
    srst = 0;
    tick(4);
    t_standby();
    t_active();
    t_data();
    t_to_standby();
    t_spike();
    t_off();
    end_of_test();
  end

  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end
endmodule

`default_nettype wire
